// ==== hdl/rtca_pkg.sv ====
package rtca_pkg;

  // ==========================================================================
  // register map, byte addresses on the APB
  // ==========================================================================
  localparam int          RTCA_ADDR_W             = 8;
  localparam logic [7:0]  RTCA_TIME_ALARM_OFS     = 8'h1c;
  localparam logic [7:0]  RTCA_CALENDAR_ALARM_OFS = 8'h20;
  localparam logic [7:0]  RTCA_LEAP_YEAR_OFS      = 8'h24;
  localparam logic [7:0]  RTCA_IRQ_ENABLE_OFS     = 8'h28;
  localparam logic [7:0]  RTCA_IRQ_FLAG_OFS       = 8'h2c;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [31:0] RTCA_TIME_ALARM_RST     = 32'h0000_0000;
  localparam logic [31:0] RTCA_CALENDAR_ALARM_RST = 32'h0000_0000;
  localparam logic        RTCA_LEAP_YEAR_RST      = 1'h0;
  localparam logic [1:0]  RTCA_IRQ_ENABLE_RST     = 2'h0;
  localparam logic [1:0]  RTCA_IRQ_FLAG_RST       = 2'h0;

  // ==========================================================================
  // digit fields of the time alarm and time counter (same layout)
  // ==========================================================================
  localparam int RTCA_HOUR_TENS_LSB   = 20;
  localparam int RTCA_HOUR_UNITS_LSB  = 16;
  localparam int RTCA_MIN_TENS_LSB    = 12;
  localparam int RTCA_MIN_UNITS_LSB   = 8;
  localparam int RTCA_SEC_TENS_LSB    = 4;
  localparam int RTCA_SEC_UNITS_LSB   = 0;
  localparam logic [31:0] RTCA_TIME_MASK = 32'h003f_7f7f;

  // ==========================================================================
  // digit fields of the calendar alarm and calendar counter (same layout)
  // ==========================================================================
  localparam int RTCA_YEAR_TENS_LSB   = 20;
  localparam int RTCA_YEAR_UNITS_LSB  = 16;
  localparam int RTCA_MONTH_TENS_LSB  = 12;
  localparam int RTCA_MONTH_UNITS_LSB = 8;
  localparam int RTCA_DAY_TENS_LSB    = 4;
  localparam int RTCA_DAY_UNITS_LSB   = 0;
  localparam logic [31:0] RTCA_CALENDAR_MASK = 32'h00ff_1f3f;

  // ==========================================================================
  // interrupt bits, same layout in enable and flag registers
  // ==========================================================================
  localparam int RTCA_IRQ_ALARM_BIT = 0;
  localparam int RTCA_IRQ_TICK_BIT  = 1;
  localparam int RTCA_IRQ_N         = 2;
  localparam int RTCA_LEAP_BIT      = 0;

  // ==========================================================================
  // tick timing: base strobe every 1/128 s, divided down to the selected period
  // ==========================================================================
  localparam int RTCA_CLK_PERIOD_NS   = 100;
  localparam int RTCA_TICK_BASE_NS    = 7812500;
  localparam int RTCA_TICK_BASE_CYCLES =
    (RTCA_TICK_BASE_NS + RTCA_CLK_PERIOD_NS - 1) / RTCA_CLK_PERIOD_NS;
  localparam int RTCA_TICK_CNT_W      = 17;
  localparam int RTCA_TICK_DIV_W      = 7;
  localparam logic [6:0] RTCA_TICK_DIV_FULL = 7'h7f;

endpackage

// ==== hdl/rtca_tick_gen.sv ====
`timescale 1ns/1ns
module rtca_tick_gen
  import rtca_pkg::*;
#(
  parameter int BASE_CYCLES = RTCA_TICK_BASE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] period_select,
  output logic            tick_pulse
);

  typedef struct packed {
    logic [RTCA_TICK_CNT_W-1:0] base_cnt;
    logic [RTCA_TICK_DIV_W-1:0] div_cnt;
    logic                       tick;
  } rtca_tick_state_t;

  rtca_tick_state_t state_reg;
  rtca_tick_state_t state_next;

  // ==========================================================================
  // base strobe and binary divider
  // ==========================================================================
  always_comb begin
    logic [RTCA_TICK_DIV_W-1:0] div_mask;
    logic                       base_strobe;
    div_mask    = RTCA_TICK_DIV_FULL >> period_select;
    base_strobe = (state_reg.base_cnt == RTCA_TICK_CNT_W'(BASE_CYCLES - 1));
    state_next  = state_reg;
    state_next.tick = 1'b0;
    if (base_strobe) begin
      state_next.base_cnt = '0;
      state_next.div_cnt  = state_reg.div_cnt + 7'h01;
      // code n fires every 2^(7-n) strobes: 1 s at code 0 down to 1/128 s
      state_next.tick = ((state_reg.div_cnt & div_mask) == div_mask);
    end else begin
      state_next.base_cnt = state_reg.base_cnt + 17'h00001;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_pulse = state_reg.tick;

endmodule

// ==== hdl/rtca_alarm_match.sv ====
`timescale 1ns/1ns
module rtca_alarm_match
  import rtca_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [31:0] time_counter,
  input  wire logic [31:0] calendar_counter,
  input  wire logic [31:0] time_alarm,
  input  wire logic [31:0] calendar_alarm,
  output logic             match_pulse
);

  typedef struct packed {
    logic matched;
    logic pulse;
  } rtca_match_state_t;

  rtca_match_state_t state_reg;
  rtca_match_state_t state_next;

  // ==========================================================================
  // digit compare and entry edge
  // ==========================================================================
  always_comb begin
    logic equal;
    // hours compare as raw digits, so 12-hour PM+20 codes match like for like
    equal = (((time_counter ^ time_alarm) & RTCA_TIME_MASK) == 32'h0000_0000) &&
            (((calendar_counter ^ calendar_alarm) & RTCA_CALENDAR_MASK)
             == 32'h0000_0000);
    state_next         = state_reg;
    state_next.matched = equal;
    // one pulse on entering the match, not for every cycle it lasts
    state_next.pulse   = equal && !state_reg.matched;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign match_pulse = state_reg.pulse;

endmodule

// ==== hdl/rtca_alarm_regs.sv ====
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
// Function
// - alarm hour tens [21:20], units [19:16]
// - alarm minute tens [14:12], units [11:8]
// - alarm second tens [6:4], units [3:0]
// - time alarm writes stored without checks
// - alarm reads only while access enabled
// - alarm year tens [23:20], units [19:16]
// - alarm month tens [12], units [11:8]
// - alarm day tens [5:4], units [3:0]
// - calendar alarm writes stored without checks
// - read-only leap year bit at 0
// - tick interrupt enable at bit 1
// - alarm interrupt enable at bit 0
// - tick flag set per period, W1C
// - alarm flag set on match, W1C
// - interrupt only from enabled set flags
// - hours in 24h or 12h PM+20 form
// - tick period 1 s down to 1/128 s
module rtca_alarm_regs
  import rtca_pkg::*;
#(
  parameter int TICK_BASE_CYCLES = RTCA_TICK_BASE_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [RTCA_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  input  wire logic [31:0]            time_counter,
  input  wire logic [31:0]            calendar_counter,
  input  wire logic [2:0]             tick_period_select,
  input  wire logic                   access_enabled_flag
);

  typedef struct packed {
    logic [31:0]             time_alarm;
    logic [31:0]             calendar_alarm;
    logic                    leap_year_flag;
    logic [RTCA_IRQ_N-1:0]   irq_enable;
    logic [RTCA_IRQ_N-1:0]   irq_flag;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    irq;
  } rtca_regs_state_t;

  localparam rtca_regs_state_t RTCA_REGS_RST = '{
    time_alarm:     RTCA_TIME_ALARM_RST,
    calendar_alarm: RTCA_CALENDAR_ALARM_RST,
    leap_year_flag: RTCA_LEAP_YEAR_RST,
    irq_enable:     RTCA_IRQ_ENABLE_RST,
    irq_flag:       RTCA_IRQ_FLAG_RST,
    prdata:         32'h0000_0000,
    pready:         1'b0,
    pslverr:        1'b0,
    irq:            1'b0
  };

  rtca_regs_state_t state_reg;
  rtca_regs_state_t state_next;

  logic tick_pulse;
  logic match_pulse;

  // ==========================================================================
  // event sources
  // ==========================================================================
  rtca_tick_gen #(
    .BASE_CYCLES (TICK_BASE_CYCLES)
  ) u_tick (
    .mclk          (mclk),
    .reset         (reset),
    .period_select (tick_period_select),
    .tick_pulse    (tick_pulse)
  );

  rtca_alarm_match u_match (
    .mclk             (mclk),
    .reset            (reset),
    .time_counter     (time_counter),
    .calendar_counter (calendar_counter),
    .time_alarm       (state_reg.time_alarm),
    .calendar_alarm   (state_reg.calendar_alarm),
    .match_pulse      (match_pulse)
  );

  // ==========================================================================
  // leap year from the running two-digit BCD year
  // ==========================================================================
  function automatic logic rtca_is_leap(input logic [3:0] tens, input logic [3:0] units);
    // (10*tens + units) mod 4 equals (2*tens + units) mod 4
    if (tens[0] == 1'b0) begin
      rtca_is_leap = (units == 4'h0) || (units == 4'h4) || (units == 4'h8);
    end else begin
      rtca_is_leap = (units == 4'h2) || (units == 4'h6);
    end
  endfunction

  // ==========================================================================
  // read mux
  // ==========================================================================
  function automatic logic [31:0] rtca_read(input rtca_regs_state_t s,
                                            input logic [RTCA_ADDR_W-1:0] addr,
                                            input logic access_ok);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (addr)
      RTCA_TIME_ALARM_OFS: begin
        // alarm settings hide behind the access-enabled flag
        if (access_ok) begin
          word = s.time_alarm & RTCA_TIME_MASK;
        end
      end
      RTCA_CALENDAR_ALARM_OFS: begin
        if (access_ok) begin
          word = s.calendar_alarm & RTCA_CALENDAR_MASK;
        end
      end
      RTCA_LEAP_YEAR_OFS: begin
        word[RTCA_LEAP_BIT] = s.leap_year_flag;
      end
      RTCA_IRQ_ENABLE_OFS: begin
        word[RTCA_IRQ_N-1:0] = s.irq_enable;
      end
      RTCA_IRQ_FLAG_OFS: begin
        word[RTCA_IRQ_N-1:0] = s.irq_flag;
      end
      default: begin
        word = 32'h0000_0000;
      end
    endcase
    rtca_read = word;
  endfunction

  function automatic logic rtca_mapped(input logic [RTCA_ADDR_W-1:0] addr);
    rtca_mapped = (addr == RTCA_TIME_ALARM_OFS) || (addr == RTCA_CALENDAR_ALARM_OFS) ||
                  (addr == RTCA_LEAP_YEAR_OFS) || (addr == RTCA_IRQ_ENABLE_OFS) ||
                  (addr == RTCA_IRQ_FLAG_OFS);
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic                  setup;
    logic                  wr;
    logic [RTCA_IRQ_N-1:0] flag_set;
    logic [RTCA_IRQ_N-1:0] flag_clr;
    setup      = psel && !penable;
    wr         = psel && penable && state_reg.pready && pwrite && rtca_mapped(paddr);
    flag_set   = '0;
    flag_clr   = '0;
    state_next = state_reg;

    // apb: one wait-free access phase, pready high in the cycle after setup
    state_next.pready  = setup;
    state_next.pslverr = setup && !rtca_mapped(paddr);
    if (setup) begin
      state_next.prdata = rtca_read(state_reg, paddr, access_enabled_flag);
    end

    if (wr) begin
      case (paddr)
        RTCA_TIME_ALARM_OFS: begin
          // digits stored as written; out-of-range bcd is software's problem
          state_next.time_alarm = pwdata & RTCA_TIME_MASK;
        end
        RTCA_CALENDAR_ALARM_OFS: begin
          state_next.calendar_alarm = pwdata & RTCA_CALENDAR_MASK;
        end
        RTCA_IRQ_ENABLE_OFS: begin
          state_next.irq_enable = pwdata[RTCA_IRQ_N-1:0];
        end
        RTCA_IRQ_FLAG_OFS: begin
          flag_clr = pwdata[RTCA_IRQ_N-1:0];
        end
        default: begin
          state_next.irq_enable = state_reg.irq_enable;
        end
      endcase
    end

    state_next.leap_year_flag = rtca_is_leap(
      calendar_counter[RTCA_YEAR_TENS_LSB +: 4],
      calendar_counter[RTCA_YEAR_UNITS_LSB +: 4]);

    // events only latch while their enable is set
    flag_set[RTCA_IRQ_TICK_BIT]  = tick_pulse && state_reg.irq_enable[RTCA_IRQ_TICK_BIT];
    flag_set[RTCA_IRQ_ALARM_BIT] = match_pulse &&
                                   state_reg.irq_enable[RTCA_IRQ_ALARM_BIT];

    // an event in the clearing cycle survives: set beats clear
    for (int i = 0; i < RTCA_IRQ_N; i++) begin
      state_next.irq_flag[i] = (state_reg.irq_flag[i] && !flag_clr[i]) || flag_set[i];
    end

    state_next.irq = |(state_next.irq_flag & state_next.irq_enable);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= RTCA_REGS_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata  = state_reg.prdata;
  assign pready  = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irq     = state_reg.irq;

endmodule

// ==== verification/rtca_alarm_regs_monitor.sv ====
`timescale 1ns/1ns
module rtca_alarm_regs_monitor
  import rtca_pkg::*;
#(
  parameter int TICK_BASE_CYCLES = RTCA_TICK_BASE_CYCLES
) (
  input wire logic                   mclk,
  input wire logic                   reset,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [RTCA_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   irq,
  input wire logic [31:0]            time_counter,
  input wire logic [31:0]            calendar_counter,
  input wire logic [2:0]             tick_period_select,
  input wire logic                   access_enabled_flag
);
  // ====================
  // bus answers
  // ====================
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_ready_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
  property p_err_map;
    pready |-> (pslverr == !(paddr inside {8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c}));
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
  property p_err_data;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("unmapped read not zero");
  property p_gate;
    pready && !pwrite && !access_enabled_flag && !$past(access_enabled_flag)
      && (paddr inside {8'h1c, 8'h20}) |-> prdata == 32'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("alarm read while access off");
  property p_time_bits;
    pready && !pwrite && paddr == 8'h1c |-> (prdata & ~RTCA_TIME_MASK) == 32'h0;
  endproperty
  a_time_bits: assert property (p_time_bits) else $error("time alarm spare bits set");
  property p_cal_bits;
    pready && !pwrite && paddr == 8'h20 |-> (prdata & ~RTCA_CALENDAR_MASK) == 32'h0;
  endproperty
  a_cal_bits: assert property (p_cal_bits) else $error("calendar spare bits set");
  property p_small_bits;
    pready && !pwrite && (paddr inside {8'h28, 8'h2c}) |-> prdata[31:2] == 30'h0;
  endproperty
  a_small_bits: assert property (p_small_bits) else $error("irq reg spare bits set");
  // ====================
  // interrupt line
  // ====================
  property p_irq_drop;
    psel && penable && pready && pwrite && paddr == 8'h28 && pwdata[1:0] == 2'h0
      |-> ##2 !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq kept after disable");
  // irq lags register writes, so the write cycles and the one cycle after them are excluded
  property p_irq_hold;
    irq && !(psel && pwrite) && !($past(psel) && $past(pwrite)) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell without write");
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_irq_off: cover property ($fell(irq));
endmodule

bind rtca_alarm_regs rtca_alarm_regs_monitor #(.TICK_BASE_CYCLES(TICK_BASE_CYCLES)) u_mon (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .time_counter(time_counter), .calendar_counter(calendar_counter),
  .tick_period_select(tick_period_select), .access_enabled_flag(access_enabled_flag));

// ==== verification/tb_rtca_alarm_regs.sv ====
`timescale 1ns/1ns
module tb_rtca_alarm_regs;
  logic        mclk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] time_counter;
  logic [31:0] calendar_counter;
  logic [2:0]  tick_period_select;
  logic        access_enabled_flag;
  logic [31:0] q;
  logic        e;
  int          n_fail;
  int          n_checks;

  // short base period keeps the 1 s tick at 512 cycles
  rtca_alarm_regs #(.TICK_BASE_CYCLES(4)) u_rtca_alarm_regs (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .time_counter(time_counter), .calendar_counter(calendar_counter),
    .tick_period_select(tick_period_select), .access_enabled_flag(access_enabled_flag));

  always #50 mclk = ~mclk;

  // ====================
  // bus tasks
  // ====================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // no cycle budget here: only the watchdog ends a wait
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next setup is a fresh assignment
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    final_report;
  end

  // ====================
  // tests
  // ====================
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    time_counter = 32'h0;
    calendar_counter = 32'h0023_0101;
    tick_period_select = 3'h7;
    access_enabled_flag = 1'b1;
    n_fail = 0;
    n_checks = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      rd(8'h1c + 8'(4 * i), 32'h0);
    end
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h003f_7f7f);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h00ff_1f3f);
    wr(8'h1c, 32'h0032_3456);
    rd(8'h1c, 32'h0032_3456);
    wr(8'h20, 32'h0024_1231);
    rd(8'h20, 32'h0024_1231);
    access_enabled_flag <= 1'b0;
    rd(8'h1c, 32'h0);
    rd(8'h20, 32'h0);
    access_enabled_flag <= 1'b1;
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24, 32'h0);
    calendar_counter <= 32'h0024_1231;
    repeat (3) @(posedge mclk);
    rd(8'h24, 32'h1);
    xfer(1'b0, 8'h30, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(8'h30, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    // match while alarm enable is off must be dropped
    time_counter <= 32'h0032_3456;
    repeat (6) @(posedge mclk);
    rd(8'h2c, 32'h0);
    time_counter <= 32'h0032_3457;
    wr(8'h28, 32'h1);
    time_counter <= 32'h0032_3456;
    repeat (6) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rd(8'h2c, 32'h1);
    wr(8'h2c, 32'h1);
    rd(8'h2c, 32'h0);
    calendar_counter <= 32'h0024_1230;
    repeat (6) @(posedge mclk);
    rd(8'h2c, 32'h0);
    chk({31'h0, irq}, 32'h0);
    calendar_counter <= 32'h0024_1231;
    repeat (6) @(posedge mclk);
    rd(8'h2c, 32'h1);
    wr(8'h28, 32'h0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h2c, 32'h1);
    wr(8'h2c, 32'h1);
    // each code must tick within its period plus margin
    for (int c = 7; c >= 0; c--) begin
      tick_period_select <= 3'(c);
      wr(8'h2c, 32'h3);
      wr(8'h28, 32'h2);
      repeat ((4 << (7 - c)) + 8) @(posedge mclk);
      rd(8'h2c, 32'h2);
    end
    rd(8'h28, 32'h2);
    chk({31'h0, irq}, 32'h1);
    // lock onto a fresh tick at code 0, then none in the next 400 cycles and one within 120 more
    wr(8'h2c, 32'h2);
    while (irq !== 1'b1) begin
      @(posedge mclk);
    end
    wr(8'h2c, 32'h2);
    repeat (400) @(posedge mclk);
    rd(8'h2c, 32'h0);
    repeat (120) @(posedge mclk);
    rd(8'h2c, 32'h2);
    wr(8'h28, 32'h0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h2c, 32'h2);
    wr(8'h2c, 32'h2);
    rd(8'h2c, 32'h0);
    tick_period_select <= 3'h7;
    repeat (40) @(posedge mclk);
    rd(8'h2c, 32'h0);
    final_report;
  end
endmodule
